// ==== pkg/ufb_pkg.sv ====
// Package for the serial frame and baud configuration block
package ufb_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses (word aligned)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_SHARED = 5'h00; // frame control / baud high
  localparam logic [4:0] ADDR_BAUD_LOW = 5'h04;
  localparam logic [4:0] ADDR_CTRL_B = 5'h08; // size high, enables, 9th bits
  localparam logic [4:0] ADDR_STATUS = 5'h0c; // sticky events, read clears
  localparam logic [4:0] ADDR_MASK = 5'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SEL_BIT = 7; // shared address select in byte lane 0
  localparam int SEL_BIT_HIGH = 15; // same select as bit 15 of the baud word
  localparam int MODE_BIT = 6;
  localparam int PAR_HI = 5;
  localparam int PAR_LO = 4;
  localparam int STOP_BIT = 3;
  localparam int SIZE_HI = 2;
  localparam int SIZE_LO = 1;
  localparam int POL_BIT = 0;
  localparam int CB_SIZE2 = 2;
  localparam int CB_DOUBLE = 3;
  localparam int CB_TXEN = 4;
  localparam int CB_RXEN = 5;
  localparam int CB_TX9 = 0;
  localparam int CB_RX9 = 1;
  localparam int ST_TXDONE = 0;
  localparam int ST_RXDONE = 1;
  localparam int ST_PERR = 2;
  localparam int ST_FERR = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] FRAME_RESET = 7'h06; // async, no parity, 1 stop, 8 bits
  localparam logic [11:0] BAUD_RESET = 12'h000;
  localparam int ASYNC_OVERSAMPLE = 16;
  localparam int DOUBLE_OVERSAMPLE = 8;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PAR_OFF = 2'h0, PAR_RSVD = 2'h1, PAR_EVEN = 2'h2, PAR_ODD = 2'h3} ufb_par_e;

  typedef struct packed {
    logic mode_select;
    ufb_par_e parity_mode;
    logic stop_bit_select;
    logic [1:0] char_size_low;
    logic clock_polarity;
  } ufb_frame_s;

  typedef struct packed {
    logic char_size_high;
    logic double_speed;
    logic tx_enable;
    logic rx_enable;
    logic tx_bit8;
  } ufb_ctrl_s;

endpackage

// ==== verilog/ufb_baud_gen.sv ====
// Baud prescaler: divisor counter producing one-cycle bit and sample ticks
`timescale 1ns/1ps
module ufb_baud_gen #(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Configuration
  input wire logic [DIV_W-1:0] i_divisor,
  input wire logic i_reload,
  input wire logic i_sync_mode,
  input wire logic i_double_speed,
  // Ticks
  output logic o_sample_tick,
  output logic o_bit_tick
);

  typedef struct packed {
    logic [DIV_W-1:0] pre;
    logic [3:0] over;
  } ufb_bg_s;

  ufb_bg_s st_ff;
  ufb_bg_s nxt_st;
  logic [3:0] over_last;
  logic pre_tick;

  // Oversample length: 16 async, 8 double speed, 2 for the sync clock halves
  always_comb begin
    if (i_sync_mode) begin
      over_last = 4'h1;
    end else if (i_double_speed) begin
      over_last = 4'(ufb_pkg::DOUBLE_OVERSAMPLE - 1);
    end else begin
      over_last = 4'(ufb_pkg::ASYNC_OVERSAMPLE - 1);
    end
  end

  // [RQ13] divisor zero ticks every clock
  assign pre_tick = (st_ff.pre == '0);

  // Prescaler counts divisor+1 clocks, reloaded on baud low writes
  always_comb begin
    nxt_st = st_ff;
    if (i_reload) begin
      nxt_st.pre = i_divisor;
      nxt_st.over = '0;
    end else if (pre_tick) begin
      nxt_st.pre = i_divisor;
      nxt_st.over = (st_ff.over >= over_last) ? 4'h0 : st_ff.over + 4'h1;
    end else begin
      nxt_st.pre = st_ff.pre - DIV_W'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sample_tick = pre_tick & ~i_reload;
  assign o_bit_tick = pre_tick & ~i_reload & (st_ff.over >= over_last);

endmodule

// ==== verilog/ufb_usart.sv ====
// Serial transceiver frame engine with frame and baud configuration registers
// Operation
// [RQ1] Transmitter computes parity over data bits and sends it in the frame.
// [RQ2] Receiver checks parity against the selected type, flags mismatch.
// [RQ3] Parity mode 00 off, 01 reserved, 10 even, 11 odd.
// [RQ4] Transmitter sends one or two stop bits; receiver ignores the setting.
// [RQ5] Size code 000..011 gives 5..8 bits, 111 nine bits, rest reserved.
// [RQ6] Sync mode: polarity 0 changes data on rising, samples on falling.
// [RQ7] Software keeps clock polarity zero in asynchronous mode.
// [RQ8] Baud high reads select bit zero; written with select zero.
// [RQ9] Software writes zeros to reserved baud high bits 14:12.
// [RQ10] Baud divisor is 12 bits: four high, eight low.
// [RQ11] Writing baud low reloads the prescaler with the full divisor.
// [RQ12] Software avoids changing the divisor during a frame.
// [RQ13] Divisor zero gives the fastest rate with no error.
// [RQ14] Mode select 0 asynchronous, 1 clocked synchronous.
// [RQ15] Double speed changes the async ratio from 16 to 8.
// [RQ16] Frame control reads select bit one; written with select one.
// [RQ17] Async rate is clock over 16 or 8 times divisor plus one.
// [RQ18] Both baud divisor bytes reset to zero.
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module ufb_usart #(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [4:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Transmit data stream
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Receive data stream
  output logic o_rx_valid,
  output logic [8:0] o_rx_data,
  // Serial pins
  output logic o_txd,
  input wire logic i_rxd,
  output logic o_sclk,
  // Interrupt
  output logic o_irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ufb_st_e;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    ufb_pkg::ufb_frame_s frame;
    ufb_pkg::ufb_ctrl_s ctrl;
    logic [DIV_W-1:0] baud;
    logic [3:0] status;
    logic [3:0] mask;
    ufb_st_e tx_st;
    logic [8:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_par;
    logic tx_stop2;
    logic txd;
    ufb_st_e rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [3:0] rx_os;
    logic rx_par;
    logic rx_valid;
    logic [8:0] rx_data;
    logic rx_prev;
    logic sclk;
  } ufb_s;

  ufb_s st_ff;
  ufb_s nxt_st;
  logic sample_tick;
  logic bit_tick;
  logic reload;
  logic wb_req;
  logic [3:0] nbits;
  logic odd_sel;
  logic sync_m;
  logic tx_step;
  logic rx_step;
  logic rx_bit;
  logic [3:0] rx_mid;
  logic [DIV_W-1:0] baud_now;

  assign wb_req = i_wb_cyc & i_wb_stb & ~st_ff.ack;
  // [RQ14] mode select bit
  assign sync_m = st_ff.frame.mode_select;
  // [RQ11] low write reloads
  assign reload = wb_req & i_wb_we & i_wb_sel[0] & (i_wb_adr == ufb_pkg::ADDR_BAUD_LOW);
  // Reload takes the full divisor as it stands after the low byte write
  assign baud_now = reload ? {st_ff.baud[DIV_W-1:8], i_wb_dat[7:0]} : st_ff.baud;

  // ---------------------------------------------------------------
  // Baud prescaler
  // ---------------------------------------------------------------
  // [RQ17] divisor plus one
  ufb_baud_gen #(.DIV_W(DIV_W)) u_baud (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_divisor(baud_now),
    .i_reload(reload),
    .i_sync_mode(sync_m),
    .i_double_speed(st_ff.ctrl.double_speed & ~sync_m),
    .o_sample_tick(sample_tick),
    .o_bit_tick(bit_tick)
  );

  // Character size decode, reserved codes fall back to eight bits
  // [RQ5] size decode
  always_comb begin
    case ({st_ff.ctrl.char_size_high, st_ff.frame.char_size_low})
      3'h0: nbits = 4'h5;
      3'h1: nbits = 4'h6;
      3'h2: nbits = 4'h7;
      3'h3: nbits = 4'h8;
      3'h7: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  end

  // [RQ3] odd only for code 11
  assign odd_sel = st_ff.frame.parity_mode == ufb_pkg::PAR_ODD;
  // Sync: step on every other clock half, edge per polarity; async: on bit tick
  // [RQ6] edge choice
  assign tx_step = sync_m ? (sample_tick & (st_ff.sclk == st_ff.frame.clock_polarity)) : bit_tick;
  // [RQ15] double speed halves ratio
  assign rx_mid = st_ff.ctrl.double_speed ? 4'h3 : 4'h7;
  assign rx_bit = st_ff.rx_prev;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.rx_valid = 1'b0;
    nxt_st.rx_prev = i_rxd;
    rx_step = 1'b0;
    // Bus access, one cycle answer
    if (wb_req) begin
      nxt_st.ack = 1'b1;
      nxt_st.rdat = '0;
      if (i_wb_we) begin
        if (i_wb_adr == ufb_pkg::ADDR_SHARED) begin
          // [RQ16] select one targets frame
          if (i_wb_sel[0] && i_wb_dat[ufb_pkg::SEL_BIT]) begin
            nxt_st.frame = ufb_pkg::ufb_frame_s'(i_wb_dat[6:0]);
          end
          // [RQ8] select zero targets baud high
          if (i_wb_sel[1] && !i_wb_dat[ufb_pkg::SEL_BIT_HIGH]) begin
            nxt_st.baud[DIV_W-1:8] = i_wb_dat[DIV_W-1:8];
          end
        end else if (i_wb_adr == ufb_pkg::ADDR_BAUD_LOW) begin
          // [RQ10] low eight bits
          if (i_wb_sel[0]) begin
            nxt_st.baud[7:0] = i_wb_dat[7:0];
          end
        end else if (i_wb_adr == ufb_pkg::ADDR_CTRL_B) begin
          if (i_wb_sel[0]) begin
            nxt_st.ctrl.char_size_high = i_wb_dat[ufb_pkg::CB_SIZE2];
            nxt_st.ctrl.double_speed = i_wb_dat[ufb_pkg::CB_DOUBLE];
            nxt_st.ctrl.tx_enable = i_wb_dat[ufb_pkg::CB_TXEN];
            nxt_st.ctrl.rx_enable = i_wb_dat[ufb_pkg::CB_RXEN];
            nxt_st.ctrl.tx_bit8 = i_wb_dat[ufb_pkg::CB_TX9];
          end
        end else if (i_wb_adr == ufb_pkg::ADDR_MASK) begin
          if (i_wb_sel[0]) begin
            nxt_st.mask = i_wb_dat[3:0];
          end
        end
      end else begin
        case (i_wb_adr)
          // Frame control in low byte with select one, baud high above with select zero
          ufb_pkg::ADDR_SHARED: nxt_st.rdat = {16'h0000, 4'h0, st_ff.baud[DIV_W-1:8], 1'b1, 7'(st_ff.frame)};
          ufb_pkg::ADDR_BAUD_LOW: nxt_st.rdat = {24'h000000, st_ff.baud[7:0]};
          ufb_pkg::ADDR_CTRL_B: nxt_st.rdat = {26'h0, st_ff.ctrl.rx_enable, st_ff.ctrl.tx_enable,
            st_ff.ctrl.double_speed, st_ff.ctrl.char_size_high, st_ff.rx_data[8], st_ff.ctrl.tx_bit8};
          ufb_pkg::ADDR_STATUS: nxt_st.rdat = {28'h0000000, st_ff.status};
          ufb_pkg::ADDR_MASK: nxt_st.rdat = {28'h0000000, st_ff.mask};
          default: nxt_st.rdat = '0;
        endcase
        if (i_wb_adr == ufb_pkg::ADDR_STATUS) begin
          nxt_st.status = '0;
        end
      end
    end

    // Sync serial clock toggles on each sample tick
    if (sync_m && sample_tick) begin
      nxt_st.sclk = ~st_ff.sclk;
    end else if (!sync_m) begin
      nxt_st.sclk = st_ff.frame.clock_polarity;
    end

    // Transmitter
    case (st_ff.tx_st)
      S_IDLE: begin
        nxt_st.txd = 1'b1;
        if (i_tx_valid && st_ff.ctrl.tx_enable) begin
          nxt_st.tx_sh = {st_ff.ctrl.tx_bit8, i_tx_data};
          nxt_st.tx_par = odd_sel;
          nxt_st.tx_st = S_START;
          nxt_st.tx_stop2 = st_ff.frame.stop_bit_select;
        end
      end
      S_START: begin
        if (tx_step) begin
          nxt_st.txd = 1'b0;
          nxt_st.tx_cnt = '0;
          nxt_st.tx_st = S_DATA;
        end
      end
      S_DATA: begin
        if (tx_step) begin
          nxt_st.txd = st_ff.tx_sh[0];
          // [RQ1] running parity
          nxt_st.tx_par = st_ff.tx_par ^ st_ff.tx_sh[0];
          nxt_st.tx_sh = {1'b0, st_ff.tx_sh[8:1]};
          nxt_st.tx_cnt = st_ff.tx_cnt + 4'h1;
          if (st_ff.tx_cnt == nbits - 4'h1) begin
            nxt_st.tx_st = st_ff.frame.parity_mode[1] ? S_PAR : S_STOP;
          end
        end
      end
      S_PAR: begin
        if (tx_step) begin
          // [RQ1] parity bit sent
          nxt_st.txd = st_ff.tx_par;
          nxt_st.tx_st = S_STOP;
        end
      end
      S_STOP: begin
        if (tx_step) begin
          nxt_st.txd = 1'b1;
          // [RQ4] second stop bit
          if (st_ff.tx_stop2) begin
            nxt_st.tx_stop2 = 1'b0;
          end else begin
            nxt_st.tx_st = S_IDLE;
            nxt_st.status[ufb_pkg::ST_TXDONE] = 1'b1;
          end
        end
      end
      default: nxt_st.tx_st = S_IDLE;
    endcase

    // Receiver sample point: mid bit async, polarity edge in sync
    if (sync_m) begin
      // [RQ6] sample on opposite edge
      rx_step = sample_tick & (st_ff.sclk != st_ff.frame.clock_polarity);
    end else begin
      rx_step = sample_tick & (st_ff.rx_os == rx_mid);
    end
    if (sample_tick && !sync_m) begin
      nxt_st.rx_os = (st_ff.rx_st == S_IDLE) ? 4'h0 :
        ((st_ff.rx_os == (st_ff.ctrl.double_speed ? 4'h7 : 4'hf)) ? 4'h0 : st_ff.rx_os + 4'h1);
    end
    case (st_ff.rx_st)
      S_IDLE: begin
        if (st_ff.ctrl.rx_enable && !rx_bit && (sync_m || sample_tick)) begin
          nxt_st.rx_st = S_START;
          nxt_st.rx_os = 4'h1;
        end
      end
      S_START: begin
        if (rx_step) begin
          nxt_st.rx_st = rx_bit ? S_IDLE : S_DATA;
          nxt_st.rx_cnt = '0;
          nxt_st.rx_sh = '0;
          nxt_st.rx_par = odd_sel;
        end
      end
      S_DATA: begin
        if (rx_step) begin
          nxt_st.rx_sh[st_ff.rx_cnt] = rx_bit;
          // [RQ2] running check
          nxt_st.rx_par = st_ff.rx_par ^ rx_bit;
          nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
          if (st_ff.rx_cnt == nbits - 4'h1) begin
            nxt_st.rx_st = st_ff.frame.parity_mode[1] ? S_PAR : S_STOP;
          end
        end
      end
      S_PAR: begin
        if (rx_step) begin
          nxt_st.rx_par = st_ff.rx_par ^ rx_bit;
          nxt_st.rx_st = S_STOP;
        end
      end
      S_STOP: begin
        // [RQ4] only first stop checked
        if (rx_step) begin
          nxt_st.rx_st = S_IDLE;
          nxt_st.rx_valid = 1'b1;
          nxt_st.rx_data = st_ff.rx_sh;
          nxt_st.status[ufb_pkg::ST_RXDONE] = 1'b1;
          // [RQ2] mismatch flag
          if (st_ff.frame.parity_mode[1] && st_ff.rx_par) begin
            nxt_st.status[ufb_pkg::ST_PERR] = 1'b1;
          end
          if (!rx_bit) begin
            nxt_st.status[ufb_pkg::ST_FERR] = 1'b1;
          end
        end
      end
      default: nxt_st.rx_st = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '0;
      st_ff.frame <= ufb_pkg::ufb_frame_s'(ufb_pkg::FRAME_RESET);
      // [RQ18] divisor zero
      st_ff.baud <= ufb_pkg::BAUD_RESET;
      st_ff.tx_st <= S_IDLE;
      st_ff.rx_st <= S_IDLE;
      st_ff.txd <= 1'b1;
      st_ff.rx_prev <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign o_wb_ack = st_ff.ack;
  assign o_wb_dat = st_ff.rdat;
  assign o_tx_ready = (st_ff.tx_st == S_IDLE) & st_ff.ctrl.tx_enable;
  assign o_rx_valid = st_ff.rx_valid;
  assign o_rx_data = st_ff.rx_data;
  assign o_txd = st_ff.txd;
  assign o_sclk = st_ff.sclk;
  assign o_irq = |(st_ff.status & st_ff.mask);

endmodule

// ==== verif/ufb_usart_checker.sv ====
// Assertion checker for the frame and baud configuration block
`timescale 1ns/1ps
module ufb_usart_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [4:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Stream and pins
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_rx_valid,
  input wire logic o_txd
);
  // --------------------------------
  // Handshake, register, stream and pin checks
  // --------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_rd;
    s_req ##0 !i_wb_we;
  endsequence
  a_ack_next: assert property (s_req |=> o_wb_ack)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_shared_sel: assert property ((s_rd ##0 i_wb_adr == ufb_pkg::ADDR_SHARED) |=> (o_wb_dat[15:12] == 4'h0 && o_wb_dat[7]))
    else $error("shared select bits wrong");
  a_unmapped_zero: assert property ((s_rd ##0 i_wb_adr[1:0] != 2'h0) |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  a_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("receive valid not a pulse");
  a_tx_busy: assert property ((i_tx_valid && o_tx_ready) |=> !o_tx_ready [*8])
    else $error("transmitter ready during frame");
  a_bit_min: assert property ($fell(o_txd) |-> !o_txd [*4])
    else $error("low bit shorter than four cycles");
endmodule
bind ufb_usart ufb_usart_checker u_chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid), .o_txd(o_txd));

// ==== verif/ufb_remote.sv ====
// Remote serial transceiver model on the transmit and receive pins
`timescale 1ns/1ps
module ufb_remote (
  // Clock reference
  input wire logic i_clock,
  // Serial pins
  input wire logic i_txd,
  output logic o_rxd
);
  // Line idles high between frames
  initial o_rxd = 1'b1;
  // Capture a frame from its start bit, sampling mid bit
  task automatic recv(input int n, input int per, output logic [15:0] v);
    v = 16'hffff;
    @(negedge i_txd);
    repeat (per / 2) @(posedge i_clock);
    for (int i = 0; i < n; i++) begin
      v[i] = i_txd;
      repeat (per) @(posedge i_clock);
    end
  endtask
  // Drive a frame first bit first, then return to idle high
  task automatic send(input int n, input int per, input logic [15:0] v);
    for (int i = 0; i < n; i++) begin
      o_rxd <= v[i];
      repeat (per) @(posedge i_clock);
    end
    o_rxd <= 1'b1;
  endtask
endmodule

// ==== verif/usart_frame_and_baud_config_tb_top.sv ====
// Self-checking bench for the frame and baud configuration block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t mismatch", $time); end end
module usart_frame_and_baud_config_tb_top;
  // --------------------------------
  // Signals and instances
  // --------------------------------
  logic i_clock, i_rstn, cyc, stb, we, tx_valid, sclk_q, txd_q, pol_now;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, dat_o;
  logic [7:0] tx_data;
  logic ack, tx_ready, rx_valid, txd, rxd, sclk, irq;
  logic [8:0] rx_data;
  int num_errors, checked, cycles, bad, edges;
  ufb_usart DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(dat_o), .o_wb_ack(ack),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_txd(txd), .i_rxd(rxd), .o_sclk(sclk), .o_irq(irq));
  ufb_remote rem (.i_clock(i_clock), .i_txd(txd), .o_rxd(rxd));
  // Clock source
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // Cycle budget and clock edge monitor
  always @(posedge i_clock) begin
    cycles++;
    if (txd !== txd_q && sclk === pol_now && sclk_q !== pol_now) bad++;
    if (sclk !== sclk_q) edges++;
    sclk_q <= sclk;
    txd_q <= txd;
    if (cycles == 40000) begin
      num_errors++;
      end_sim();
    end
  end
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge i_clock); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Program baud and frame; select and reserved bits kept as required
  task automatic cfg(input logic [2:0] code, input logic [1:0] par, input logic stp, md, pol, u2x,
    input logic [11:0] div);
    wb(1'b1, ufb_pkg::ADDR_SHARED, 4'h2, {20'h0, div[11:8], 8'h00});
    wb(1'b1, ufb_pkg::ADDR_BAUD_LOW, 4'h1, {24'h0, div[7:0]});
    wb(1'b1, ufb_pkg::ADDR_SHARED, 4'h1, {24'h0, 1'b1, md, par, stp, code[1:0], pol & md});
    wb(1'b1, ufb_pkg::ADDR_CTRL_B, 4'h1, {26'h0, 2'b11, u2x, code[2], 2'b01});
  endtask
  // Offer one byte and count cycles until the transmitter is free again
  task automatic tx(input logic [7:0] d, output int c);
    c = 0;
    @(posedge i_clock);
    tx_valid <= 1'b1;
    tx_data <= d;
    do @(posedge i_clock); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    // Time the frame from its start bit, so the free running phase drops out
    do @(posedge i_clock); while (txd !== 1'b0);
    do begin
      @(posedge i_clock);
      c++;
    end while (tx_ready !== 1'b1 && c < 5000);
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_regs();
    wb(1'b0, ufb_pkg::ADDR_SHARED, 4'hf, 32'h0);
    `CHK(rdat[15:0], {8'h00, 1'b1, ufb_pkg::FRAME_RESET})
    wb(1'b0, ufb_pkg::ADDR_BAUD_LOW, 4'hf, 32'h0);
    `CHK(rdat[7:0], 8'h00)
    wb(1'b1, ufb_pkg::ADDR_SHARED, 4'h2, 32'h0000_0a00);
    wb(1'b1, ufb_pkg::ADDR_BAUD_LOW, 4'h1, 32'h0000_005c);
    wb(1'b0, ufb_pkg::ADDR_SHARED, 4'hf, 32'h0);
    `CHK(rdat[15:0], 16'h0a86)
    wb(1'b0, ufb_pkg::ADDR_BAUD_LOW, 4'hf, 32'h0);
    `CHK(rdat[7:0], 8'h5c)
    wb(1'b0, 5'h02, 4'hf, 32'h0);
    `CHK(rdat, 32'h0)
    $display("registers test done");
  endtask
  task automatic t_frames();
    logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
    logic [1:0] par [6] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
    logic [5:0] stp = 6'b001010;
    logic [5:0] u2x = 6'b100110;
    logic [15:0] v, e;
    logic [8:0] d;
    logic p;
    int nb, per, n, c;
    for (int i = 0; i < 6; i++) begin
      cfg(code[i], par[i], stp[i], 1'b0, 1'b0, u2x[i], {11'h0, i[0]});
      per = (i % 2 + 1) * (u2x[i] ? 8 : 16);
      nb = (code[i] == 3'h7) ? 9 : (code[i] < 3'h4) ? 5 + code[i] : 8;
      d = {1'b1, 8'ha1 + 8'(i)};
      e = 16'hffff;
      e[0] = 1'b0;
      p = par[i][0];
      for (int k = 0; k < nb; k++) begin
        e[k + 1] = d[k];
        p = p ^ e[k + 1];
      end
      if (par[i][1]) e[nb + 1] = p;
      n = 2 + nb + par[i][1] + stp[i];
      fork
        rem.recv(n, per, v);
        tx(d[7:0], c);
      join
      // frame content per size and parity code
      `CHK(v, e)
      // stop count and rate: start edge to idle is all bits but the last stop
      `CHK(c, (n - 1) * per)
    end
    $display("frames test done");
  endtask
  task automatic t_sync();
    int c;
    for (int k = 0; k < 2; k++) begin
      pol_now = k[0];
      cfg(3'h3, 2'h0, 1'b0, 1'b1, k[0], 1'b0, 12'h001);
      bad = 0;
      edges = 0;
      tx(8'h96, c);
      `CHK(c, 36)
      `CHK(bad, 0)
      `CHK(edges > 8, 1'b1)
    end
    $display("sync test done");
  endtask
  task automatic t_rx();
    int c;
    cfg(3'h3, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000);
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, ufb_pkg::ADDR_MASK, 4'h1, 32'h0);
      wb(1'b0, ufb_pkg::ADDR_STATUS, 4'hf, 32'h0);
      c = 0;
      fork
        rem.send(11, 16, {5'h1f, 1'b1, k[0], 8'h3c, 1'b0});
        do begin
          @(posedge i_clock);
          c++;
        end while (rx_valid !== 1'b1 && c < 400);
      join
      `CHK(c < 400, 1'b1)
      `CHK(rx_data[7:0], 8'h3c)
      `CHK(irq, 1'b0)
      wb(1'b1, ufb_pkg::ADDR_MASK, 4'h1, 32'h1 << ufb_pkg::ST_PERR);
      repeat (2) @(posedge i_clock);
      `CHK(irq, k[0])
      wb(1'b0, ufb_pkg::ADDR_STATUS, 4'hf, 32'h0);
      `CHK(rdat[ufb_pkg::ST_PERR], k[0])
      wb(1'b0, ufb_pkg::ADDR_STATUS, 4'hf, 32'h0);
      repeat (2) @(posedge i_clock);
      `CHK({rdat[ufb_pkg::ST_PERR], irq}, 2'b00)
    end
    $display("receive test done");
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {i_rstn, cyc, stb, we, tx_valid, pol_now} = 6'h0;
    {adr, sel, tx_data, wdat} = 49'h0;
    repeat (12) @(posedge i_clock);
    i_rstn <= 1'b1;
    t_regs();
    t_frames();
    t_sync();
    t_rx();
    end_sim();
  end
endmodule
